//--- shared/ebmp_pkg.sv
package ebmp_pkg;

  // ---------------------------------------------------------------------
  // Register word offsets (byte addresses on the Wishbone bus)
  // ---------------------------------------------------------------------
  localparam logic [3:0] EBMP_ADR_BUS_MISC = 4'h0;
  localparam logic [3:0] EBMP_ADR_RSVD = 4'h4;
  localparam logic [3:0] EBMP_ADR_IRQ_CTL = 4'h8;
  localparam logic [3:0] EBMP_ADR_PORT_DATA = 4'hc;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int EBMP_BIT_E_STRETCH = 0;
  localparam int EBMP_BIT_IRQ_EDGE = 7;
  localparam int EBMP_BIT_IRQ_CONNECT = 6;
  localparam int EBMP_BIT_EMUL_SEL = 7;
  localparam int EBMP_BIT_EXT_SEL = 6;
  localparam int EBMP_PAGE_BITS = 6;
  localparam logic EBMP_RST_IRQ_CONNECT = 1'b1;
  localparam logic [7:0] EBMP_ZERO_BYTE = 8'h00;

  // Quarter-cycle deselect after a falling E edge, in bus clocks
  localparam int unsigned EBMP_DESEL_CYC = 1;

  // ---------------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    EBMP_MODE_SPECIAL_SC = 3'h0,
    EBMP_MODE_EMUL_NARROW = 3'h1,
    EBMP_MODE_SPECIAL_TEST = 3'h2,
    EBMP_MODE_EMUL_WIDE = 3'h3,
    EBMP_MODE_NORMAL_SC = 3'h4,
    EBMP_MODE_NORMAL_NARROW = 3'h5,
    EBMP_MODE_PERIPHERAL = 3'h6,
    EBMP_MODE_NORMAL_WIDE = 3'h7
  } ebmp_mode_t;

  // Bus side of the block, kept as one carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ebmp_wb_req_t;

  // Pin side of the expansion port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull;
  } ebmp_port_pins_t;

endpackage : ebmp_pkg

//--- rtl/ebmp_top.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Stretch bit clear: E clock free running
// - Stretch set: E high stretched, low internal
// - Stretch bit write-once normal, anytime special
// - Stretch bit ignored in single-chip modes
// - Control and reserved unmapped when expanded
// - Reserved location reads zero, ignores writes
// - Edge select readable; write-once unless special
// - Level-low or falling-edge pin recognition
// - Edge latch cleared by reset or service
// - Connect bit always writable; disconnects pin
// - Connect clear holds edge latch disabled
// - Direction one drives pin, zero floats
// - Data read: pin for inputs, latch outputs
// - Port registers unmapped expanded with emulate
// - Input pins pulled up when pull enabled
// - Bit 7 emulation select, quarter deselect
// - Bit 6 external select, same deselect
// - Bits 5:0 page address or general I/O
// - Port mapped single-chip, never peripheral
// - Reset sets stretch bit in every mode
module ebmp_top
  import ebmp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic ext_access_o,
  input wire logic [2:0] mode_i,
  input wire logic page_port_emulate_i,
  input wire logic page_port_pull_enable_i,
  input wire logic ext_cycle_i,
  input wire logic stretched_i,
  input wire logic visible_i,
  input wire logic e_phase_i,
  input wire logic emul_hit_i,
  input wire logic [5:0] page_address_bits_i,
  input wire logic irq_n_i,
  input wire logic irq_service_i,
  output logic irq_req_o,
  output logic bus_e_clock_o,
  input wire logic [7:0] port_pin_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe_n_o,
  output logic [7:0] port_pull_o
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic e_stretch_enable;
    logic e_stretch_written;
    logic irq_edge_select;
    logic irq_edge_written;
    logic irq_pin_connect;
    logic irq_pin_d1;
    logic irq_edge_latch;
    logic [7:0] page_port_data;
    logic [7:0] page_port_direction;
    logic ack;
    logic [31:0] rdata;
    logic ext;
    logic e_clk;
    logic e_prev;
    logic desel;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
  } ebmp_state_t;

  ebmp_state_t s_q;
  ebmp_state_t s_d;

  ebmp_mode_t mode;
  logic is_special;
  logic is_single_chip;
  logic is_peripheral;
  logic is_emul;
  logic ctl_mapped;
  logic port_mapped;
  logic port_emulating;
  logic req;
  logic hit;
  logic e_fall;
  logic [7:0] port_read;
  logic [31:0] rd_word;
  logic [3:0] adr_w;

  // -----------------------------------------------------------------------
  // Mode decode
  // -----------------------------------------------------------------------
  assign mode = ebmp_mode_t'(mode_i);
  assign is_special = (mode == EBMP_MODE_SPECIAL_SC) ||
                      (mode == EBMP_MODE_SPECIAL_TEST) ||
                      (mode == EBMP_MODE_PERIPHERAL);
  assign is_single_chip = (mode == EBMP_MODE_SPECIAL_SC) ||
                          (mode == EBMP_MODE_NORMAL_SC);
  assign is_peripheral = (mode == EBMP_MODE_PERIPHERAL);
  assign is_emul = (mode == EBMP_MODE_EMUL_NARROW) ||
                   (mode == EBMP_MODE_EMUL_WIDE);
  // Control and reserved words live on-chip only in single-chip modes
  assign ctl_mapped = is_single_chip;
  assign port_emulating = !is_single_chip && !is_peripheral &&
                          page_port_emulate_i;
  assign port_mapped = is_single_chip ||
                       (!is_peripheral && !page_port_emulate_i);

  assign req = cyc_i && stb_i && !s_q.ack;
  assign adr_w = {adr_i[3:2], 2'b00};
  assign e_fall = s_q.e_prev && !e_phase_i;

  // Data read mixes pin level and output latch per direction bit
  assign port_read = (port_pin_i & ~s_q.page_port_direction) |
                     (s_q.page_port_data & s_q.page_port_direction);

  // -----------------------------------------------------------------------
  // Read decode
  // -----------------------------------------------------------------------
  always_comb
  begin
    rd_word = '0;
    hit = 1'b0;
    case (adr_w)
      EBMP_ADR_BUS_MISC:
      begin
        hit = ctl_mapped;
        rd_word[EBMP_BIT_E_STRETCH] = s_q.e_stretch_enable;
      end
      EBMP_ADR_RSVD:
      begin
        hit = ctl_mapped;
        rd_word[7:0] = EBMP_ZERO_BYTE;
      end
      EBMP_ADR_IRQ_CTL:
      begin
        hit = 1'b1;
        rd_word[EBMP_BIT_IRQ_EDGE] = s_q.irq_edge_select;
        rd_word[EBMP_BIT_IRQ_CONNECT] = s_q.irq_pin_connect;
      end
      EBMP_ADR_PORT_DATA:
      begin
        hit = port_mapped;
        rd_word[7:0] = port_read;
        rd_word[15:8] = s_q.page_port_direction;
      end
      default:
      begin
        hit = 1'b0;
        rd_word = '0;
      end
    endcase
  end

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.ack = req;
    s_d.ext = req && !hit;
    s_d.rdata = (req && hit) ? rd_word : '0;

    if (req && we_i && hit)
    begin
      case (adr_w)
        EBMP_ADR_BUS_MISC:
        begin
          if (sel_i[0] && (is_special || !s_q.e_stretch_written))
          begin
            s_d.e_stretch_enable = dat_i[EBMP_BIT_E_STRETCH];
            s_d.e_stretch_written = 1'b1;
          end
        end
        EBMP_ADR_IRQ_CTL:
        begin
          if (sel_i[0])
          begin
            if (is_special || !s_q.irq_edge_written)
            begin
              s_d.irq_edge_select = dat_i[EBMP_BIT_IRQ_EDGE];
              s_d.irq_edge_written = 1'b1;
            end
            s_d.irq_pin_connect = dat_i[EBMP_BIT_IRQ_CONNECT];
          end
        end
        EBMP_ADR_PORT_DATA:
        begin
          if (sel_i[0])
          begin
            s_d.page_port_data = dat_i[7:0];
          end
          if (sel_i[1])
          begin
            s_d.page_port_direction = dat_i[15:8];
          end
        end
        default:
        begin
          s_d.ack = req;
        end
      endcase
    end

    // Interrupt edge detect
    s_d.irq_pin_d1 = irq_n_i;
    if (!s_q.irq_pin_connect)
    begin
      s_d.irq_edge_latch = 1'b0;
    end
    else if (s_q.irq_edge_select && s_q.irq_pin_d1 && !irq_n_i)
    begin
      s_d.irq_edge_latch = 1'b1;
    end
    else if (irq_service_i)
    begin
      s_d.irq_edge_latch = 1'b0;
    end

    // E clock: free running unless stretch enabled outside single chip
    s_d.e_prev = e_phase_i;
    if (!s_q.e_stretch_enable || is_single_chip)
    begin
      s_d.e_clk = e_phase_i;
    end
    else if (ext_cycle_i && stretched_i)
    begin
      s_d.e_clk = 1'b1;
    end
    else if (!ext_cycle_i && !visible_i)
    begin
      s_d.e_clk = 1'b0;
    end
    else
    begin
      s_d.e_clk = e_phase_i;
    end

    // Chip selects release briefly after each falling E edge, except when stretched_i is set with stretch disabled
    s_d.desel = e_fall &&
                !(stretched_i && !s_q.e_stretch_enable);

    if (port_emulating)
    begin
      s_d.pin_out[EBMP_BIT_EMUL_SEL] = !emul_hit_i || s_d.desel;
      s_d.pin_out[EBMP_BIT_EXT_SEL] =
        !(ext_cycle_i && !emul_hit_i) || s_d.desel;
      s_d.pin_out[EBMP_PAGE_BITS-1:0] = page_address_bits_i;
      s_d.pin_oe_n = '0;
    end
    else
    begin
      s_d.pin_out = s_q.page_port_data;
      s_d.pin_oe_n = ~s_q.page_port_direction;
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.e_stretch_enable <= 1'b1;
      s_q.irq_pin_connect <= EBMP_RST_IRQ_CONNECT;
      s_q.irq_pin_d1 <= 1'b1;
      s_q.pin_oe_n <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign dat_o = s_q.rdata;
  assign ack_o = s_q.ack;
  assign ext_access_o = s_q.ext;
  assign bus_e_clock_o = s_q.e_clk;
  assign port_pin_o = s_q.pin_out;
  assign port_pin_oe_n_o = s_q.pin_oe_n;
  // Pull-ups only on pins currently floating as inputs; follows the
  // registered enables so a pin is never pulled and driven at once
  assign port_pull_o = {8{page_port_pull_enable_i}} &
    s_q.pin_oe_n;
  assign irq_req_o = s_q.irq_pin_connect &&
    (s_q.irq_edge_select ? s_q.irq_edge_latch : !s_q.irq_pin_d1);

endmodule // ebmp_top
`default_nettype wire

//--- verif/ebmp_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ebmp_asserts
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic ext_access_o,
  input wire logic [2:0] mode_i,
  input wire logic page_port_emulate_i,
  input wire logic page_port_pull_enable_i,
  input wire logic e_phase_i,
  input wire logic [5:0] page_address_bits_i,
  input wire logic irq_n_i,
  input wire logic irq_req_o,
  input wire logic bus_e_clock_o,
  input wire logic [7:0] port_pin_o,
  input wire logic [7:0] port_pin_oe_n_o,
  input wire logic [7:0] port_pull_o
);
  // ----------------------------------------
  // Bus, map and pin relations
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic tk;
  logic sc;
  assign tk = cyc_i && stb_i && !ack_o;
  assign sc = mode_i[1:0] == 2'h0;
  ack_once_a: assert property (tk |=> ack_o ##1 !ack_o)
    else $error("ack is not one pulse");
  rsvd_zero_a: assert property (
    tk && sc && adr_i[3:2] == 2'h1 |=> dat_o == 32'h0)
    else $error("reserved read not zero");
  ctl_unmap_a: assert property (
    tk && !sc && !adr_i[3] |=> ext_access_o && dat_o == 32'h0)
    else $error("control word not echoed");
  port_unmap_a: assert property (
    tk && !sc && adr_i[3:2] == 2'h3
    && (mode_i == 3'h6 || page_port_emulate_i) |=> ext_access_o)
    else $error("port word not echoed");
  port_map_a: assert property (
    tk && sc && adr_i[3:2] == 2'h3 |=> !ext_access_o)
    else $error("port word echoed in single chip");
  e_free_a: assert property (
    sc |=> bus_e_clock_o == $past(e_phase_i))
    else $error("e clock not free in single chip");
  pull_in_a: assert property (
    port_pull_o == (port_pin_oe_n_o & {8{page_port_pull_enable_i}}))
    else $error("pull not on inputs only");
  irq_low_a: assert property (
    $rose(irq_req_o) |-> !$past(irq_n_i) || !$past(irq_n_i, 2)
    || !$past(irq_n_i, 3))
    else $error("request without low pin");
  page_bits_a: assert property (
    mode_i[0] && page_port_emulate_i
    |=> port_pin_o[5:0] == $past(page_address_bits_i))
    else $error("page bits not on port");
  cover property (tk && ext_access_o);
  cover property ($rose(irq_req_o));
  cover property (mode_i[0] && page_port_emulate_i);
endmodule // ebmp_asserts

bind ebmp_top ebmp_asserts ebmp_asserts_i (
  .clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .dat_o, .ack_o,
  .ext_access_o, .mode_i, .page_port_emulate_i,
  .page_port_pull_enable_i, .e_phase_i, .page_address_bits_i,
  .irq_n_i, .irq_req_o, .bus_e_clock_o, .port_pin_o,
  .port_pin_oe_n_o, .port_pull_o);
`default_nettype wire

//--- verif/ebmp_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module ebmp_pin_model
  import ebmp_pkg::*;
(
  input wire logic clk_i,
  input wire ebmp_port_pins_t pins_i,
  output logic [7:0] level_o
);
  // ----------------------------------------
  // Driven, pulled up, or floating pins
  // ----------------------------------------
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge clk_i)
  begin
    float_q <= ~float_q;
  end
  assign level_o = (~pins_i.oe_n & pins_i.out)
    | (pins_i.oe_n & (pins_i.pull | float_q));
endmodule // ebmp_pin_model
`default_nettype wire

//--- verif/test_ebmp_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_ebmp_top;
  import ebmp_pkg::*;
  logic clk_i = 0, rst_i = 1, irq_n_i = 1, irq_service_i = 0;
  logic cyc_i = 0, stb_i = 0, we_i = 0, e_phase_i = 0, ext;
  logic page_port_emulate_i = 0, page_port_pull_enable_i = 1;
  logic ext_cycle_i = 0, stretched_i = 0, visible_i = 0;
  logic emul_hit_i = 0, ack_o, irq_req_o, bus_e_clock_o, ext_access_o;
  logic [2:0] mode_i = 3'h4;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
  logic [5:0] page_address_bits_i = 6'h2d;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [7:0] port_pin_i, port_pin_o, port_pin_oe_n_o, port_pull_o;
  // Mode, emulate, offset, echoed
  logic [8:0] tab [7] = '{9'h1c1, 9'h1c9, 9'h1d8, 9'h1f9, 9'h199,
    9'h138, 9'h1d0};
  int mismatches = 0, comparisons = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) e_phase_i <= ~e_phase_i;
  ebmp_top ebmp_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .ext_access_o, .mode_i,
    .page_port_emulate_i, .page_port_pull_enable_i, .ext_cycle_i,
    .stretched_i, .visible_i, .e_phase_i, .emul_hit_i,
    .page_address_bits_i, .irq_n_i, .irq_service_i, .irq_req_o,
    .bus_e_clock_o, .port_pin_i, .port_pin_o, .port_pin_oe_n_o,
    .port_pull_o);
  ebmp_pin_model ebmp_pin_model_i (.clk_i,
    .pins_i({port_pin_o, port_pin_oe_n_o, port_pull_o}),
    .level_o(port_pin_i));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic reset(input logic [2:0] m);
    mode_i <= m;
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      mismatches++;
    rd = dat_o;
    ext = ext_access_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic wrc(input logic [3:0] a, input logic [7:0] d, m, e);
    wb(1, a, 4'hf, {24'h0, d});
    wb(0, a, 4'hf, 32'h0);
    check(rd[7:0] & m, e);
  endtask
  task automatic wait_irq(input logic e);
    repeat (8)
    begin
      @(posedge clk_i);
      if (irq_req_o === e)
        break;
    end
    check({7'h0, irq_req_o}, {7'h0, e});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    wb(0, EBMP_ADR_BUS_MISC, 4'hf, 32'h0);
    check(rd[7:0] & 8'h01, 8'h01);
    wb(0, EBMP_ADR_IRQ_CTL, 4'hf, 32'h0);
    check(rd[7:0] & 8'hc0, 8'h40);
  endtask
  task automatic t_once;
    wrc(EBMP_ADR_BUS_MISC, 8'h00, 8'h01, 8'h00);
    wrc(EBMP_ADR_BUS_MISC, 8'h01, 8'h01, 8'h00);
    wrc(EBMP_ADR_IRQ_CTL, 8'h80, 8'hc0, 8'h80);
    wrc(EBMP_ADR_IRQ_CTL, 8'h40, 8'hc0, 8'hc0);
    wrc(EBMP_ADR_RSVD, 8'hff, 8'hff, 8'h00);
  endtask
  task automatic t_map;
    foreach (tab[i])
    begin
      mode_i <= tab[i][8:6];
      page_port_emulate_i <= tab[i][5];
      wb(0, tab[i][4:1], 4'hf, 32'h0);
      check({7'h0, ext}, {7'h0, tab[i][0]});
    end
    mode_i <= 3'h4;
    page_port_emulate_i <= 0;
  endtask
  task automatic t_port;
    wb(1, EBMP_ADR_PORT_DATA, 4'h1, 32'h5a);
    wb(1, EBMP_ADR_PORT_DATA, 4'h2, 32'h0f00);
    @(posedge clk_i);
    wb(0, EBMP_ADR_PORT_DATA, 4'hf, 32'h0);
    check(rd[7:0], 8'hfa);
    check(rd[15:8], 8'h0f);
    check(port_pin_oe_n_o, 8'hf0);
    check(port_pin_o & 8'h0f, 8'h0a);
    check(port_pull_o, 8'hf0);
    page_port_pull_enable_i <= 0;
    @(posedge clk_i);
    check(port_pull_o, 8'h00);
  endtask
  task automatic t_special;
    wrc(EBMP_ADR_BUS_MISC, 8'h00, 8'h01, 8'h00);
    wrc(EBMP_ADR_BUS_MISC, 8'h01, 8'h01, 8'h01);
    wrc(EBMP_ADR_IRQ_CTL, 8'h80, 8'hc0, 8'h80);
    wrc(EBMP_ADR_IRQ_CTL, 8'h40, 8'hc0, 8'h40);
  endtask
  task automatic t_irq;
    irq_n_i <= 0;
    wait_irq(1);
    irq_n_i <= 1;
    wait_irq(0);
    wrc(EBMP_ADR_IRQ_CTL, 8'hc0, 8'hc0, 8'hc0);
    irq_n_i <= 0;
    repeat (3) @(posedge clk_i);
    irq_n_i <= 1;
    wait_irq(1);
    repeat (6) @(posedge clk_i);
    check({7'h0, irq_req_o}, 8'h01);
    irq_service_i <= 1;
    @(posedge clk_i);
    irq_service_i <= 0;
    wait_irq(0);
    wrc(EBMP_ADR_IRQ_CTL, 8'h80, 8'hc0, 8'h80);
    irq_n_i <= 0;
    repeat (3) @(posedge clk_i);
    irq_n_i <= 1;
    wrc(EBMP_ADR_IRQ_CTL, 8'hc0, 8'hc0, 8'hc0);
    repeat (6) @(posedge clk_i);
    check({7'h0, irq_req_o}, 8'h00);
  endtask
  task automatic t_bus_e_clock;
    wrc(EBMP_ADR_BUS_MISC, 8'h00, 8'h01, 8'h00);
    mode_i <= 3'h2;
    repeat (4) @(posedge clk_i);
    check({7'h0, bus_e_clock_o}, {7'h0, ~e_phase_i});
    mode_i <= 3'h0;
    wrc(EBMP_ADR_BUS_MISC, 8'h01, 8'h01, 8'h01);
    mode_i <= 3'h2;
    repeat (4) @(posedge clk_i);
    check({7'h0, bus_e_clock_o}, 8'h00);
    ext_cycle_i <= 1;
    stretched_i <= 1;
    repeat (4) @(posedge clk_i);
    check({7'h0, bus_e_clock_o}, 8'h01);
    mode_i <= 3'h0;
    wrc(EBMP_ADR_BUS_MISC, 8'h00, 8'h01, 8'h00);
    mode_i <= 3'h3;
    page_port_emulate_i <= 1;
    emul_hit_i <= 1;
    repeat (4) @(posedge clk_i);
    check(port_pin_o, 8'h6d);
    check(port_pin_oe_n_o, 8'h00);
    emul_hit_i <= 0;
    repeat (2) @(posedge clk_i);
    check(port_pin_o, 8'had);
  endtask
  initial
  begin
    #400000;
    mismatches++;
    results;
  end
  initial
  begin
    reset(3'h4);
    t_reset;
    t_once;
    t_map;
    t_port;
    reset(3'h0);
    t_special;
    t_irq;
    t_bus_e_clock;
    results;
  end
endmodule // test_ebmp_top
`default_nettype wire
